// >>> gcal_pkg.sv
// package: register map, reset values and constants of the gain and excitation slice
package gcal_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] GAIN_CAL_LOW_OFS  = 8'h0A; // gain word bits 7:0
  localparam logic [7:0] GAIN_CAL_MID_OFS  = 8'h0B; // gain word bits 15:8
  localparam logic [7:0] GAIN_CAL_HIGH_OFS = 8'h0C; // gain word bits 23:16
  localparam logic [7:0] ROUTING_OFS       = 8'h0D; // current source routing
  localparam logic [7:0] LEVEL_OFS         = 8'h0E; // current source level
  localparam logic [7:0] STATUS_OFS        = 8'h1F; // read-only slice status

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] GAIN_CAL_LOW_RST  = 8'h00;
  localparam logic [7:0] GAIN_CAL_MID_RST  = 8'h00;
  localparam logic [7:0] GAIN_CAL_HIGH_RST = 8'h40;
  localparam logic [7:0] ROUTING_RST       = 8'hBB; // both sources unconnected
  localparam logic [7:0] LEVEL_RST         = 8'h00; // both sources off

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  localparam logic [23:0] GAIN_UNITY     = 24'h400000; // coefficient of one
  localparam int          GAIN_FRAC_BITS = 22;         // divide by 400000h
  localparam int          OFS_ALIGN_BITS = 8;          // offset word left shift
  localparam logic [31:0] SAT_MAX        = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_MIN        = 32'h80000000;

  // ----------------------------------------
  // field layout and codes
  // ----------------------------------------
  localparam int         SECOND_FIELD_LSB = 4;     // bits 7:4
  localparam int         FIRST_FIELD_LSB  = 0;     // bits 3:0
  localparam int         ROUTE_PIN_CNT    = 11;    // nine plus one inputs, common
  localparam logic [3:0] ROUTE_COMMON     = 4'hA;  // common analog input
  localparam logic [3:0] ROUTE_NONE       = 4'hB;  // no connection
  localparam logic [3:0] LEVEL_MAX_CODE   = 4'hA;  // 3000 uA
  localparam int         STAT_SAT_BIT     = 0;
  localparam int         STAT_ROUTE_BIT   = 1;
  localparam int         STAT_LEVEL_BIT   = 2;

  // magnitude in microamps per level code
  localparam logic [11:0] LEVEL_UA [0:10] = '{
    12'h000, 12'h032, 12'h064, 12'h0FA, 12'h1F4, 12'h2EE,
    12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hBB8
  };

endpackage

// >>> gcal_isrc.sv
// module: decoder for one excitation current source
`timescale 1ns/1ps
module gcal_isrc (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // codes from the register file
  input  wire logic [3:0]  route_code,
  input  wire logic [3:0]  level_code,
  // decoded controls
  output logic      [10:0] pin_en,
  output logic      [11:0] level_ua,
  output logic             route_bad,
  output logic             level_bad
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [10:0] pin_en;  // one-hot pin switch, bit 10 is common
    logic [11:0] ua;      // magnitude in microamps
    logic        rbad;    // reserved routing code
    logic        lbad;    // reserved level code
  } gcal_isrc_st_t;

  gcal_isrc_st_t st_reg;  // registered copy
  gcal_isrc_st_t st_next; // next copy
  logic [10:0]   pin_hit; // raw compare per pin

  // one comparator per pin; no connection and reserved codes hit none
  genvar g;
  generate
    for (g = 0; g < gcal_pkg::ROUTE_PIN_CNT; g++) begin : g_pin
      assign pin_hit[g] = (route_code == 4'(g));
    end
  endgenerate

  // next state
  always_comb begin
    st_next        = st_reg;
    st_next.pin_en = pin_hit;
    st_next.rbad   = (route_code > gcal_pkg::ROUTE_NONE);
    st_next.lbad   = (level_code > gcal_pkg::LEVEL_MAX_CODE);
    // reserved magnitudes are held off rather than guessed
    if (level_code <= gcal_pkg::LEVEL_MAX_CODE) begin
      st_next.ua = gcal_pkg::LEVEL_UA[level_code];
    end else begin
      st_next.ua = 12'h000;
    end
  end

  // register; reset matches routing BBh and level 00h
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_en    = st_reg.pin_en;
  assign level_ua  = st_reg.ua;
  assign route_bad = st_reg.rbad;
  assign level_bad = st_reg.lbad;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_level_off_zero: assert property (level_code == 4'h0 |=> level_ua == 12'h000)
    else $error("current source not off for code zero");
  a_route_one_hot: assert property ($onehot0(pin_en))
    else $error("current source routed to more than one pin");

endmodule // gcal_isrc

// >>> gcal_corr.sv
// module: offset subtract, gain multiply and saturation of conversion results
`timescale 1ns/1ps
module gcal_corr (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // raw result and calibration words
  input  wire logic        conv_valid,
  input  wire logic [31:0] conv_data,
  input  wire logic [23:0] offset_word,
  input  wire logic [23:0] gain_word,
  // corrected result
  output logic             out_valid,
  output logic      [31:0] out_data,
  output logic             out_sat
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic        s1_valid; // difference stage holds a sample
    logic [32:0] s1_diff;  // signed difference, one guard bit
    logic [23:0] s1_gain;  // gain word taken with the sample
    logic        valid;    // corrected result strobe
    logic [31:0] data;     // corrected result
    logic        sat;      // result was clamped
  } gcal_corr_st_t;

  gcal_corr_st_t      st_reg;
  gcal_corr_st_t      st_next;
  logic signed [32:0] ofs_aligned; // offset word moved up to result scale
  logic signed [32:0] diff_now;    // result minus offset
  logic signed [57:0] prod;        // difference times unsigned gain
  logic signed [35:0] scaled;      // product divided by 400000h

  // arithmetic; the shift floors toward minus infinity
  always_comb begin
    ofs_aligned = $signed({offset_word[23], offset_word, 8'h00});
    diff_now    = $signed({conv_data[31], conv_data}) - ofs_aligned;
    prod        = $signed(st_reg.s1_diff) * $signed({1'b0, st_reg.s1_gain});
    scaled      = prod[57:gcal_pkg::GAIN_FRAC_BITS];
  end

  // next state: stage one subtracts, stage two scales and clamps
  always_comb begin
    st_next          = st_reg;
    st_next.s1_valid = conv_valid;
    st_next.valid    = st_reg.s1_valid;
    if (conv_valid) begin
      st_next.s1_diff = diff_now;
      st_next.s1_gain = gain_word;
    end
    if (st_reg.s1_valid) begin
      // wrapping would flip the sign of a large reading
      if (scaled[35:31] == 5'h00 || scaled[35:31] == 5'h1F) begin
        st_next.data = scaled[31:0];
        st_next.sat  = 1'b0;
      end else if (scaled[35]) begin
        st_next.data = gcal_pkg::SAT_MIN;
        st_next.sat  = 1'b1;
      end else begin
        st_next.data = gcal_pkg::SAT_MAX;
        st_next.sat  = 1'b1;
      end
    end
  end

  // register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid;
  assign out_data  = st_reg.data;
  assign out_sat   = st_reg.sat;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_unity_take;
    conv_valid && gain_word == gcal_pkg::GAIN_UNITY && offset_word == 24'h000000;
  endsequence

  a_offset_first: assert property (conv_valid |=>
    $signed(st_reg.s1_diff) == $signed({$past(conv_data[31]), $past(conv_data)})
      - $signed({$past(offset_word), 8'h00}))
    else $error("offset not subtracted before scaling");
  a_unity_gain: assert property (s_unity_take |-> ##2
    out_valid && out_data == $past(conv_data, 2))
    else $error("unity gain word changed the result");
  a_gain_unsigned: assert property (conv_valid && gain_word == 24'h800000
    && offset_word == 24'h000000 && conv_data == 32'h00000010
    |-> ##2 out_data == 32'h00000020 && !out_sat)
    else $error("gain word treated as signed");
  a_sat_clamp: assert property (conv_valid && gain_word == 24'hFFFFFF
    && offset_word == 24'h000000 && conv_data == 32'h7FFFFFFF
    |-> ##2 out_sat && out_data == gcal_pkg::SAT_MAX)
    else $error("overflow not clamped to maximum");

endmodule // gcal_corr

// >>> gcal_regs.sv
// module: gain calibration and excitation current register slice
//
// Notes on behaviour
// - gain word from bytes at 0Ah, 0Bh, 0Ch.
// - gain word is unsigned straight binary.
// - gain coefficient is word over 400000h.
// - multiply result by gain after offset step.
// - gain bytes reset to 00h, 00h, 40h.
// - routing bits 7:4 place second source.
// - routing bits 3:0 place first source.
// - routing register resets to BBh, unconnected.
// - level bits 7:4 set second source current.
// - level bits 3:0 set first source current.
// - level register resets to 00h, sources off.
// - subtract offset word before the multiply.
// - offset word signed, shifted up eight bits.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module gcal_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // offset word from the neighbouring slice
  input  wire logic [23:0] offset_cal_word,
  // raw conversion results
  input  wire logic        conv_valid,
  input  wire logic [31:0] conv_data,
  // corrected conversion results
  output logic             corr_valid,
  output logic      [31:0] corr_data,
  output logic             corr_sat,
  // first current source controls
  output logic      [10:0] first_source_pin_en,
  output logic      [11:0] first_source_ua,
  // second current source controls
  output logic      [10:0] second_source_pin_en,
  output logic      [11:0] second_source_ua
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] gain_low;   // gain word bits 7:0
    logic [7:0] gain_mid;   // gain word bits 15:8
    logic [7:0] gain_high;  // gain word bits 23:16
    logic [7:0] routing;    // both routing fields
    logic [7:0] level;      // both level fields
    logic [7:0] rdata;      // read answer
  } gcal_regs_st_t;

  gcal_regs_st_t st_reg;       // registered copy
  gcal_regs_st_t st_next;      // next copy
  logic [23:0]   gain_cal_word; // assembled gain word
  logic [7:0]    status;        // live status byte
  logic          first_rbad;    // first source reserved route
  logic          first_lbad;    // first source reserved level
  logic          second_rbad;   // second source reserved route
  logic          second_lbad;   // second source reserved level

  // ----------------------------------------
  // field views
  // ----------------------------------------

  // three bytes form one word, low byte at the lowest offset
  assign gain_cal_word = {st_reg.gain_high, st_reg.gain_mid, st_reg.gain_low};

  // status collects what the datapath and decoders report
  always_comb begin
    status = 8'h00;
    status[gcal_pkg::STAT_SAT_BIT]   = corr_sat;
    status[gcal_pkg::STAT_ROUTE_BIT] = first_rbad | second_rbad;
    status[gcal_pkg::STAT_LEVEL_BIT] = first_lbad | second_lbad;
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------

  // writes land in the addressed byte; reads answer the next cycle only
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 8'h00;
    // write decode; the status byte and unmapped offsets ignore writes
    if (reg_wr) begin
      if (reg_addr == gcal_pkg::GAIN_CAL_LOW_OFS) begin
        st_next.gain_low = reg_wdata;
      end else if (reg_addr == gcal_pkg::GAIN_CAL_MID_OFS) begin
        st_next.gain_mid = reg_wdata;
      end else if (reg_addr == gcal_pkg::GAIN_CAL_HIGH_OFS) begin
        st_next.gain_high = reg_wdata;
      end else if (reg_addr == gcal_pkg::ROUTING_OFS) begin
        // reserved codes are stored as written so software sees them back
        st_next.routing = reg_wdata;
      end else if (reg_addr == gcal_pkg::LEVEL_OFS) begin
        st_next.level = reg_wdata;
      end
    end
    // read decode; unmapped offsets read as zero
    if (reg_rd) begin
      if (reg_addr == gcal_pkg::GAIN_CAL_LOW_OFS) begin
        st_next.rdata = st_reg.gain_low;
      end else if (reg_addr == gcal_pkg::GAIN_CAL_MID_OFS) begin
        st_next.rdata = st_reg.gain_mid;
      end else if (reg_addr == gcal_pkg::GAIN_CAL_HIGH_OFS) begin
        st_next.rdata = st_reg.gain_high;
      end else if (reg_addr == gcal_pkg::ROUTING_OFS) begin
        st_next.rdata = st_reg.routing;
      end else if (reg_addr == gcal_pkg::LEVEL_OFS) begin
        st_next.rdata = st_reg.level;
      end else if (reg_addr == gcal_pkg::STATUS_OFS) begin
        st_next.rdata = status;
      end
    end
  end

  // register with reset values: unity gain, sources parked and off
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.gain_low  <= gcal_pkg::GAIN_CAL_LOW_RST;
      st_reg.gain_mid  <= gcal_pkg::GAIN_CAL_MID_RST;
      st_reg.gain_high <= gcal_pkg::GAIN_CAL_HIGH_RST;
      st_reg.routing   <= gcal_pkg::ROUTING_RST;
      st_reg.level     <= gcal_pkg::LEVEL_RST;
      st_reg.rdata     <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;

  // ----------------------------------------
  // correction datapath
  // ----------------------------------------

  // a gain write landing mid-sample only affects later samples,
  // since the word is taken alongside each raw result
  gcal_corr u_corr (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .conv_valid  (conv_valid),
    .conv_data   (conv_data),
    .offset_word (offset_cal_word),
    .gain_word   (gain_cal_word),
    .out_valid   (corr_valid),
    .out_data    (corr_data),
    .out_sat     (corr_sat)
  );

  // ----------------------------------------
  // excitation current sources
  // ----------------------------------------

  // first source uses the low fields
  gcal_isrc u_first_source (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .route_code (st_reg.routing[gcal_pkg::FIRST_FIELD_LSB +: 4]),
    .level_code (st_reg.level[gcal_pkg::FIRST_FIELD_LSB +: 4]),
    .pin_en     (first_source_pin_en),
    .level_ua   (first_source_ua),
    .route_bad  (first_rbad),
    .level_bad  (first_lbad)
  );

  // second source uses the high fields
  gcal_isrc u_second_source (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .route_code (st_reg.routing[gcal_pkg::SECOND_FIELD_LSB +: 4]),
    .level_code (st_reg.level[gcal_pkg::SECOND_FIELD_LSB +: 4]),
    .pin_en     (second_source_pin_en),
    .level_ua   (second_source_ua),
    .route_bad  (second_rbad),
    .level_bad  (second_lbad)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // write then two cycles for decode to reach the pins
  sequence s_route_write;
    reg_wr && reg_addr == gcal_pkg::ROUTING_OFS;
  endsequence

  sequence s_level_write;
    reg_wr && reg_addr == gcal_pkg::LEVEL_OFS;
  endsequence

  a_gain_reset: assert property ($rose(arst_n) |->
    gain_cal_word == gcal_pkg::GAIN_UNITY)
    else $error("gain word not unity after reset");
  a_route_reset: assert property ($rose(arst_n) |->
    st_reg.routing == 8'hBB ##1 first_source_pin_en == 11'h000)
    else $error("routing not parked after reset");
  a_level_reset: assert property ($rose(arst_n) |->
    st_reg.level == 8'h00 ##1 second_source_ua == 12'h000)
    else $error("sources not off after reset");
  a_gain_high_map: assert property (reg_wr && reg_addr == 8'h0C |=>
    gain_cal_word[23:16] == $past(reg_wdata))
    else $error("high gain byte not stored in bits 23:16");
  a_gain_low_map: assert property (reg_wr && reg_addr == 8'h0A |=>
    gain_cal_word[7:0] == $past(reg_wdata))
    else $error("low gain byte not stored in bits 7:0");
  a_second_route: assert property ((s_route_write and reg_wdata == 8'hA3) |-> ##2
    second_source_pin_en == 11'h400 && first_source_pin_en == 11'h008)
    else $error("routing fields misplaced");
  a_first_route: assert property ((s_route_write and reg_wdata[3:0] == 4'hB) |-> ##2
    first_source_pin_en == 11'h000)
    else $error("first source connected for no-connection code");
  a_level_fields: assert property ((s_level_write and reg_wdata == 8'hA1) |-> ##2
    second_source_ua == 12'hBB8 && first_source_ua == 12'h032)
    else $error("level fields misplaced or mistabled");
  a_read_once: assert property (reg_rd && reg_addr == gcal_pkg::LEVEL_OFS
    && !reg_wr ##1 !reg_rd |-> reg_rdata == st_reg.level ##1 reg_rdata == 8'h00)
    else $error("read answer not one cycle");

endmodule // gcal_regs

// >>> gcal_regs_tb.sv
// testbench: register, excitation and correction checks of the gain slice
`timescale 1ns/1ps
module gcal_regs_tb;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        core_clk = 1'b0;          // 40 MHz core clock
  logic        arst_n   = 1'b0;          // async reset, active low
  logic [7:0]  reg_addr = 8'h00;         // register offset
  logic [7:0]  reg_wdata = 8'h00;        // write data
  logic        reg_wr   = 1'b0;          // write strobe
  logic        reg_rd   = 1'b0;          // read strobe
  logic [7:0]  reg_rdata;                // read data
  logic [23:0] offset_cal_word = 24'h000000; // offset word from neighbour
  logic        conv_valid = 1'b0;        // raw result strobe
  logic [31:0] conv_data  = 32'h00000000; // raw result
  logic        corr_valid;               // corrected strobe
  logic [31:0] corr_data;                // corrected result
  logic        corr_sat;                 // clamp flag
  logic [10:0] first_source_pin_en;      // first source switch
  logic [11:0] first_source_ua;          // first source current
  logic [10:0] second_source_pin_en;     // second source switch
  logic [11:0] second_source_ua;         // second source current
  int          err_total = 0;            // mismatches seen
  int          checks    = 0;            // comparisons made
  int          cyc       = 0;            // cycle count for the hang guard
  logic [7:0]  rv;                       // last read value
  // microamps per level code, own copy so a wrong package table is caught
  logic [11:0] ua_tab [0:15] = '{12'h000, 12'h032, 12'h064, 12'h0FA, 12'h1F4, 12'h2EE,
    12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hBB8, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

  // ----------------------------------------
  // design under test
  // ----------------------------------------
  gcal_regs DUT (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .offset_cal_word(offset_cal_word), .conv_valid(conv_valid), .conv_data(conv_data),
    .corr_valid(corr_valid), .corr_data(corr_data), .corr_sat(corr_sat),
    .first_source_pin_en(first_source_pin_en), .first_source_ua(first_source_ua),
    .second_source_pin_en(second_source_pin_en), .second_source_ua(second_source_ua)
  );

  // clock: half period 12.5 ns
  always #12.5 core_clk = ~core_clk;

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks = checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one-cycle write; the strobe drops at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read; data stand only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // read and compare one register
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    rd(a, rv);
    chk(rv, exp, msg);
  endtask

  // reference correction: offset aligned and subtracted, unsigned gain, floor, clamp
  function automatic logic [32:0] model(input logic [31:0] d, input logic [23:0] o,
                                        input logic [23:0] g);
    logic signed [32:0] diff;
    logic signed [57:0] prod;
    logic signed [57:0] q;
    diff = $signed({d[31], d}) - $signed({o[23], o, 8'h00});
    prod = diff * $signed({1'b0, g});
    q    = prod >>> 22;
    if ((&q[57:31]) || !(|q[57:31]))
      return {1'b0, q[31:0]};
    return {1'b1, (q[57] ? 32'h80000000 : 32'h7FFFFFFF)};
  endfunction

  // one raw sample in, corrected sample out two cycles later for one cycle
  task automatic conv(input logic [31:0] d, input logic [23:0] o, input logic [23:0] g);
    logic [32:0] e;
    e = model(d, o, g);
    @(posedge core_clk);
    conv_valid      <= 1'b1;
    conv_data       <= d;
    offset_cal_word <= o;
    @(posedge core_clk);
    conv_valid      <= 1'b0;
    conv_data       <= ~d;                       // stale data must not be used
    #1;
    chk(corr_valid, 32'h0, "early result");
    @(posedge core_clk);
    #1;
    chk(corr_valid, 32'h1, "result strobe");
    chk(corr_data, e[31:0], "corrected data");
    chk(corr_sat, e[32], "clamp flag");
    @(posedge core_clk);
    #1;
    chk(corr_valid, 32'h0, "strobe length");
  endtask

  // gain word byte by byte
  task automatic set_gain(input logic [23:0] g);
    wr(gcal_pkg::GAIN_CAL_LOW_OFS, g[7:0]);
    wr(gcal_pkg::GAIN_CAL_MID_OFS, g[15:8]);
    wr(gcal_pkg::GAIN_CAL_HIGH_OFS, g[23:16]);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // values after reset, unmapped space, ignored writes
  task automatic t_reset();
    chk(first_source_pin_en, 32'h0, "first pin after reset");
    chk(second_source_pin_en, 32'h0, "second pin after reset");
    chk(first_source_ua, 32'h0, "first ua after reset");
    chk(second_source_ua, 32'h0, "second ua after reset");
    rchk(8'h0A, 8'h00, "gain low reset");
    rchk(8'h0B, 8'h00, "gain mid reset");
    rchk(8'h0C, 8'h40, "gain high reset");
    rchk(8'h0D, 8'hBB, "routing reset");
    rchk(8'h0E, 8'h00, "level reset");
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 32'h0, "read data one cycle only");
    wr(8'h20, 8'h5A);
    rchk(8'h20, 8'h00, "unmapped read");
    wr(gcal_pkg::STATUS_OFS, 8'hFF);
    rchk(8'h0A, 8'h00, "status write leaks");
  endtask

  // every routing code on both fields, mirrored so the fields differ
  task automatic t_route();
    logic [3:0] c;
    logic [3:0] n;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      n = 4'hF - c;
      wr(8'h0D, {n, c});
      @(posedge core_clk);
      #1;
      chk(first_source_pin_en, (c < 4'hB) ? (32'h1 << c) : 32'h0, "first route");
      chk(second_source_pin_en, (n < 4'hB) ? (32'h1 << n) : 32'h0, "second route");
      rchk(8'h0D, {n, c}, "routing readback");
      rd(gcal_pkg::STATUS_OFS, rv);
      chk(rv[1], (c > 4'hB) || (n > 4'hB), "reserved route flag");
    end
    wr(8'h0D, 8'hA3);
    @(posedge core_clk);
    #1;
    chk(second_source_pin_en, 32'h400, "second route common");
    chk(first_source_pin_en, 32'h8, "first route pin three");
    wr(8'h0D, 8'hBB);
  endtask

  // every level code on both fields
  task automatic t_level();
    logic [3:0] c;
    logic [3:0] n;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      n = 4'hF - c;
      wr(8'h0E, {n, c});
      @(posedge core_clk);
      #1;
      chk(first_source_ua, ua_tab[c], "first level");
      chk(second_source_ua, ua_tab[n], "second level");
      rd(gcal_pkg::STATUS_OFS, rv);
      chk(rv[2], (c > 4'hA) || (n > 4'hA), "reserved level flag");
    end
    wr(8'h0E, 8'hA1);
    @(posedge core_clk);
    #1;
    chk(second_source_ua, 32'hBB8, "second level top");
    chk(first_source_ua, 32'h32, "first level lowest");
  endtask

  // correction path at several gains, offsets and clamp corners
  task automatic t_gain();
    conv(32'h87654321, 24'h000000, 24'h400000);
    conv(32'h12345678, 24'h000100, 24'h400000);
    conv(32'h00001000, 24'hFFFFFF, 24'h400000);
    set_gain(24'h200000);
    rchk(8'h0A, 8'h00, "gain low");
    rchk(8'h0C, 8'h20, "gain high");
    conv(32'hFFFFFFFF, 24'h000000, 24'h200000);
    conv(32'h00000003, 24'h000000, 24'h200000);
    set_gain(24'hFFFFFF);
    conv(32'h7FFFFFFF, 24'h000000, 24'hFFFFFF);
    rd(gcal_pkg::STATUS_OFS, rv);
    chk(rv[0], 32'h1, "clamp status");
    conv(32'h80000000, 24'h000000, 24'hFFFFFF);
    set_gain(24'h123456);
    rchk(8'h0B, 8'h34, "gain mid");
    conv(32'h7FFFFFFF, 24'h800000, 24'h123456);
    conv(32'hC0000001, 24'h7FFFFF, 24'h123456);
    set_gain(24'h800000);
    conv(32'h00000010, 24'h000000, 24'h800000);
  endtask

  // reset in mid run brings the registers back
  task automatic t_rereset();
    wr(8'h0E, 8'h55);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(first_source_ua, 32'h0, "ua in reset");
    @(posedge core_clk);
    arst_n <= 1'b1;
    rchk(8'h0C, 8'h40, "gain high re-reset");
    rchk(8'h0E, 8'h00, "level re-reset");
    conv(32'h00ABCDEF, 24'h000010, 24'h400000);
  endtask

  // ----------------------------------------
  // closing report
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    chk(reg_rdata, 32'h0, "read data in reset");
    @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_route();
    t_level();
    t_gain();
    t_rereset();
    stop_test();
  end

endmodule // gcal_regs_tb
